// ===== mpcap_pkg.sv
package mpcap_pkg;

  // parameter addresses on the fieldbus, one per parameter, each read as a 32-bit word, only the edge select and command words writable
  localparam logic [15:0] ADDR_STATUS = 16'h0a02;
  localparam logic [15:0] ADDR_EDGE_A = 16'h0a04;
  localparam logic [15:0] ADDR_EDGE_B = 16'h0a06;
  localparam logic [15:0] ADDR_CMD_A  = 16'h0a08;
  localparam logic [15:0] ADDR_CMD_B  = 16'h0a0a;
  localparam logic [15:0] ADDR_CNT_A  = 16'h0a2e;
  localparam logic [15:0] ADDR_POS_A  = 16'h0a30;
  localparam logic [15:0] ADDR_CNT_B  = 16'h0a32;
  localparam logic [15:0] ADDR_POS_B  = 16'h0a34;

  // start/stop command values
  localparam logic [31:0] CMD_STOP = 32'h0000_0000;
  localparam logic [31:0] CMD_ONCE = 32'h0000_0001;
  localparam logic [31:0] CMD_CONT = 32'h0000_0002;
  localparam logic [31:0] CMD_MAX  = 32'h0000_0004;

  // edge select values
  localparam logic [1:0]  EDGE_FALL  = 2'h0;
  localparam logic [1:0]  EDGE_RISE  = 2'h1;
  localparam logic [1:0]  EDGE_BOTH  = 2'h2;
  localparam logic [31:0] EDGE_MAX_A = 32'h0000_0002;
  localparam logic [31:0] EDGE_MAX_B = 32'h0000_0001;

  // status word bit positions
  localparam int STAT_BIT_A = 0;
  localparam int STAT_BIT_B = 1;

  // reset values
  localparam logic [1:0]  RST_EDGE   = 2'h0;
  localparam logic [15:0] RST_COUNT  = 16'h0000;
  localparam logic [31:0] RST_POS    = 32'h0000_0000;
  localparam logic [1:0]  RST_STATUS = 2'h0;

  typedef enum logic [1:0] {
    MPCAP_IDLE,
    MPCAP_ONCE,
    MPCAP_CONT
  } mpcap_mode_e;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [31:0] wdata;
  } mpcap_req_s;

  typedef struct packed {
    mpcap_mode_e mode;
    logic [1:0]  edge_sel;
    logic [1:0]  sync;
    logic        prev;
    logic [15:0] count;
    logic [31:0] raw_pos;
    logic [31:0] read_pos;
  } mpcap_chan_s;

  typedef struct packed {
    mpcap_chan_s [1:0] chan;
    logic [1:0]        status;
    logic [31:0]       rdata;
    logic              ack;
  } mpcap_state_s;

endpackage

// ===== mpcap_capture.sv
`timescale 1ns/10ps

module mpcap_capture #(
  parameter int NUM_CHANNELS = 2
) (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_reset_n,
  // parameter access
  input  wire mpcap_pkg::mpcap_req_s i_req,
  output logic [31:0]               o_rdata,
  output logic                      o_ack,
  // motion control
  input  wire logic [31:0]          i_position,
  input  wire logic                 i_pos_set,
  input  wire logic [31:0]          i_pos_delta,
  // capture pins
  input  wire logic                 i_trigger_a,
  input  wire logic                 i_trigger_b,
  // status
  output logic [1:0]                o_status
);

  if (NUM_CHANNELS < 1 || NUM_CHANNELS > 2)
  begin : g_bad_channels
    $error("mpcap_capture: NUM_CHANNELS must be 1 or 2");
  end

  mpcap_pkg::mpcap_state_s q;
  mpcap_pkg::mpcap_state_s n;

  logic [1:0]  trig;
  logic [1:0]  wr_cmd;
  logic [1:0]  activate;
  logic [1:0]  wr_edge;
  logic [1:0]  rd_cnt;
  logic [1:0]  qualify;
  logic [1:0]  strobe;
  logic [1:0]  armed;

  assign trig = {i_trigger_b, i_trigger_a};

  for (genvar i = 0; i < 2; i++)
  begin : g_dec
    localparam logic        PRESENT  = (i < NUM_CHANNELS);
    localparam logic [15:0] A_CMD    = (i == 0) ? mpcap_pkg::ADDR_CMD_A
                                                : mpcap_pkg::ADDR_CMD_B;
    localparam logic [15:0] A_EDGE   = (i == 0) ? mpcap_pkg::ADDR_EDGE_A
                                                : mpcap_pkg::ADDR_EDGE_B;
    localparam logic [15:0] A_CNT    = (i == 0) ? mpcap_pkg::ADDR_CNT_A
                                                : mpcap_pkg::ADDR_CNT_B;
    localparam logic [31:0] EDGE_MAX = (i == 0) ? mpcap_pkg::EDGE_MAX_A
                                                : mpcap_pkg::EDGE_MAX_B;
    // values above the maximum are refused, the old setting stays
    assign wr_cmd[i]   = PRESENT && i_req.wr && i_req.addr == A_CMD &&
                         i_req.wdata <= mpcap_pkg::CMD_MAX;
    assign activate[i] = wr_cmd[i] &&
                         (i_req.wdata == mpcap_pkg::CMD_ONCE ||
                          i_req.wdata == mpcap_pkg::CMD_CONT);
    assign wr_edge[i]  = PRESENT && i_req.wr && i_req.addr == A_EDGE &&
                         i_req.wdata <= EDGE_MAX;
    assign rd_cnt[i]   = PRESENT && i_req.rd && i_req.addr == A_CNT;
    // edge on the second stage against its delayed copy
    always_comb
    begin
      unique case (q.chan[i].edge_sel)
        mpcap_pkg::EDGE_FALL: qualify[i] = q.chan[i].prev & ~q.chan[i].sync[1];
        mpcap_pkg::EDGE_RISE: qualify[i] = ~q.chan[i].prev & q.chan[i].sync[1];
        mpcap_pkg::EDGE_BOTH: qualify[i] = q.chan[i].prev ^ q.chan[i].sync[1];
        default:              qualify[i] = 1'b0;
      endcase
    end
    // a start written this cycle already arms the channel
    assign armed[i]  = wr_cmd[i] ? activate[i]
                                 : (q.chan[i].mode != mpcap_pkg::MPCAP_IDLE);
    assign strobe[i] = PRESENT && armed[i] && qualify[i];
  end

  always_comb
  begin
    n = q;
    n.ack = i_req.rd | i_req.wr;
    n.rdata = '0;
    for (int i = 0; i < 2; i++)
    begin
      n.chan[i].sync = {q.chan[i].sync[0], trig[i]};
      n.chan[i].prev = q.chan[i].sync[1];
      if (i_pos_set)
      begin
        // keep old captures valid in the new reference frame
        n.chan[i].raw_pos  = q.chan[i].raw_pos + i_pos_delta;
        n.chan[i].read_pos = q.chan[i].read_pos + i_pos_delta;
      end
      if (rd_cnt[i])
      begin
        n.chan[i].read_pos = n.chan[i].raw_pos;
      end
      if (wr_edge[i])
      begin
        n.chan[i].edge_sel = i_req.wdata[1:0];
      end
      if (wr_cmd[i])
      begin
        // reserved values 3 and 4 are accepted and act as cancel
        unique case (i_req.wdata)
          mpcap_pkg::CMD_ONCE: n.chan[i].mode = mpcap_pkg::MPCAP_ONCE;
          mpcap_pkg::CMD_CONT: n.chan[i].mode = mpcap_pkg::MPCAP_CONT;
          default:             n.chan[i].mode = mpcap_pkg::MPCAP_IDLE;
        endcase
      end
      if (activate[i])
      begin
        n.chan[i].count = mpcap_pkg::RST_COUNT;
        n.status[i] = 1'b0;
      end
      if (strobe[i])
      begin
        // capture after clears so a same-cycle event is never lost
        n.chan[i].raw_pos = i_position;
        n.chan[i].count = n.chan[i].count + 16'h0001;
        n.status[i] = 1'b1;
        if (n.chan[i].mode == mpcap_pkg::MPCAP_ONCE)
        begin
          n.chan[i].mode = mpcap_pkg::MPCAP_IDLE;
        end
      end
    end
    if (i_req.rd)
    begin
      unique case (i_req.addr)
        mpcap_pkg::ADDR_STATUS: n.rdata = {30'h0, q.status};
        mpcap_pkg::ADDR_EDGE_A: n.rdata = {30'h0, q.chan[0].edge_sel};
        mpcap_pkg::ADDR_EDGE_B: n.rdata = {30'h0, q.chan[1].edge_sel};
        mpcap_pkg::ADDR_CMD_A:  n.rdata = {30'h0, q.chan[0].mode};
        mpcap_pkg::ADDR_CMD_B:  n.rdata = {30'h0, q.chan[1].mode};
        mpcap_pkg::ADDR_CNT_A:  n.rdata = {16'h0, q.chan[0].count};
        mpcap_pkg::ADDR_POS_A:  n.rdata = q.chan[0].read_pos;
        mpcap_pkg::ADDR_CNT_B:  n.rdata = {16'h0, q.chan[1].count};
        mpcap_pkg::ADDR_POS_B:  n.rdata = q.chan[1].read_pos;
        default:                n.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      for (int i = 0; i < 2; i++)
      begin
        q.chan[i].mode     <= mpcap_pkg::MPCAP_IDLE;
        q.chan[i].edge_sel <= mpcap_pkg::RST_EDGE;
        q.chan[i].sync     <= 2'h0;
        q.chan[i].prev     <= 1'b0;
        q.chan[i].count    <= mpcap_pkg::RST_COUNT;
        q.chan[i].raw_pos  <= mpcap_pkg::RST_POS;
        q.chan[i].read_pos <= mpcap_pkg::RST_POS;
      end
      q.status <= mpcap_pkg::RST_STATUS;
      q.rdata  <= 32'h0000_0000;
      q.ack    <= 1'b0;
    end
    else
    begin
      q <= n;
    end
  end

  assign o_rdata  = q.rdata;
  assign o_ack    = q.ack;
  assign o_status = q.status;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  for (genvar i = 0; i < 2; i++)
  begin : g_chk
    a_once_disarm: assert property (
      strobe[i] && !wr_cmd[i] && q.chan[i].mode == mpcap_pkg::MPCAP_ONCE
      |=> q.chan[i].mode == mpcap_pkg::MPCAP_IDLE &&
          (!strobe[i] || activate[i]))
      else $error("single shot channel stayed armed");
    a_cont_armed: assert property (
      q.chan[i].mode == mpcap_pkg::MPCAP_CONT && !wr_cmd[i]
      |=> q.chan[i].mode == mpcap_pkg::MPCAP_CONT)
      else $error("continuous channel disarmed without cancel");
    a_cmd_decode: assert property (
      wr_cmd[i] && !strobe[i]
      |=> q.chan[i].mode == (($past(i_req.wdata) == mpcap_pkg::CMD_ONCE) ?
          mpcap_pkg::MPCAP_ONCE : ($past(i_req.wdata) == mpcap_pkg::CMD_CONT) ?
          mpcap_pkg::MPCAP_CONT : mpcap_pkg::MPCAP_IDLE))
      else $error("start/stop command decoded wrongly");
    a_count_step: assert property (
      strobe[i] && !activate[i]
      |=> q.chan[i].count == $past(q.chan[i].count) + 16'h0001)
      else $error("event counter did not step by one");
    a_count_clear: assert property (
      activate[i] |=> q.chan[i].count == {15'h0, $past(strobe[i])})
      else $error("event counter not cleared on activation");
    a_status_set: assert property (
      strobe[i] |=> q.status[i] && o_status[i])
      else $error("status bit not set by capture");
    a_pos_latch: assert property (
      strobe[i] |=> q.chan[i].raw_pos == $past(i_position))
      else $error("captured position differs from live position");
    a_pos_shift: assert property (
      i_pos_set && !strobe[i] && !rd_cnt[i]
      |=> q.chan[i].read_pos ==
          $past(q.chan[i].read_pos) + $past(i_pos_delta))
      else $error("readable position not shifted with reference");
    a_read_freeze: assert property (
      rd_cnt[i] && !i_pos_set
      |=> q.chan[i].read_pos == $past(q.chan[i].raw_pos))
      else $error("counter read did not refresh position copy");
    a_freeze_hold: assert property (
      !rd_cnt[i] && !i_pos_set |=> $stable(q.chan[i].read_pos))
      else $error("frozen position changed without counter read");
    a_one_strobe: assert property (
      strobe[i] |-> q.chan[i].prev != q.chan[i].sync[1])
      else $error("strobe without a synchronised edge");
  end

  a_b_absent: assert property (
    NUM_CHANNELS < 2 |-> !strobe[1] && q.chan[1].count == mpcap_pkg::RST_COUNT)
    else $error("absent second channel captured");
  a_b_no_both: assert property (
    q.chan[1].edge_sel != mpcap_pkg::EDGE_BOTH)
    else $error("second channel took both-edge setting");

  c_once_cap: cover property (
    q.chan[0].mode == mpcap_pkg::MPCAP_ONCE && strobe[0]);
  c_cont_two: cover property (
    q.chan[0].mode == mpcap_pkg::MPCAP_CONT && strobe[0] ##[1:40] strobe[0]);
  c_read_cnt: cover property (strobe[1] ##[1:40] rd_cnt[1]);
  c_pos_set:  cover property (i_pos_set && q.status[0]);

endmodule

// ===== mpcap_dummy_unused.sv
`timescale 1ns/10ps

// ===== mpcap_trig_model.sv
`timescale 1ns/10ps

module mpcap_trig_model (
  // clock
  input  wire logic i_clk,
  // capture pins, idle low
  output logic      o_trig_a,
  output logic      o_trig_b
);
  initial
  begin
    o_trig_a = 1'b0;
    o_trig_b = 1'b0;
  end

  // each level held whole cycles, shorter ones could slip the synchroniser
  task automatic pulse(input bit ch, input int width);
    if (ch)
      o_trig_b = 1'b1;
    else
      o_trig_a = 1'b1;
    repeat (width) @(negedge i_clk);
    if (ch)
      o_trig_b = 1'b0;
    else
      o_trig_a = 1'b0;
    repeat (width) @(negedge i_clk);
  endtask
endmodule

// ===== motor_position_capture_tb.sv
`timescale 1ns/10ps

module motor_position_capture_tb;
  logic                  i_clk;
  logic                  i_reset_n;
  logic                  i_pos_set;
  logic                  trig_a;
  logic                  trig_b;
  logic                  o_ack;
  logic [1:0]            o_status;
  logic [1:0]            status1;
  logic [31:0]           i_position;
  logic [31:0]           i_pos_delta;
  logic [31:0]           o_rdata;
  logic [31:0]           last;
  logic [31:0]           expq[$];
  logic [31:0]           cv[6] = '{0, 1, 2, 5, 3, 4};
  logic [31:0]           ev[6] = '{0, 1, 2, 2, 0, 0};
  mpcap_pkg::mpcap_req_s i_req;
  int                    mismatches;
  int                    cmp_count;

  mpcap_capture #(.NUM_CHANNELS(2)) DUT (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(i_req),
    .o_rdata(o_rdata), .o_ack(o_ack), .i_position(i_position),
    .i_pos_set(i_pos_set), .i_pos_delta(i_pos_delta),
    .i_trigger_a(trig_a), .i_trigger_b(trig_b), .o_status(o_status));

  // one-channel build on the same stimulus, channel b must stay dead
  mpcap_capture #(.NUM_CHANNELS(1)) DUT_ONE (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(i_req),
    .o_rdata(), .o_ack(), .i_position(i_position),
    .i_pos_set(i_pos_set), .i_pos_delta(i_pos_delta),
    .i_trigger_a(trig_a), .i_trigger_b(trig_b), .o_status(status1));

  mpcap_trig_model TRIG (.i_clk(i_clk), .o_trig_a(trig_a), .o_trig_b(trig_b));

  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, seen);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // the note is queued before the request, the monitor pops it on ack
  task automatic acc(input logic r, w, input logic [15:0] a,
                     input logic [31:0] wd, e);
    expq.push_back(e);
    @(negedge i_clk);
    i_req = '{rd: r, wr: w, addr: a, wdata: wd};
    @(negedge i_clk);
    i_req = '0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    acc(1'b1, 1'b0, a, 32'h0, e);
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] wd);
    acc(1'b0, 1'b1, a, wd, 32'h0);
  endtask

  task automatic chk_stat(input logic [1:0] e);
    @(negedge i_clk);
    chk("status", {30'h0, e}, {30'h0, o_status});
  endtask

  always @(negedge i_clk)
    if (o_ack === 1'b1)
    begin
      if (expq.size() == 0)
        chk("unexpected ack", 32'h0, 32'h1);
      else
        chk("read data", expq.pop_front(), o_rdata);
    end

  initial
  begin
    // tests need well under 1000 cycles, this allows 5000
    #100_000;
    mismatches++;
    conclude();
  end

  initial
  begin
    i_req = '0;
    i_reset_n = 1'b0;
    i_pos_set = 1'b0;
    i_position = 32'h0;
    i_pos_delta = 32'h0;
    void'($urandom(79592));
    repeat (5) @(negedge i_clk);
    i_reset_n = 1'b1;
    rd(mpcap_pkg::ADDR_STATUS, 32'h0);
    rd(mpcap_pkg::ADDR_CNT_A, 32'h0);
    rd(mpcap_pkg::ADDR_POS_A, 32'h0);
    wr(mpcap_pkg::ADDR_STATUS, 32'h3);
    rd(mpcap_pkg::ADDR_STATUS, 32'h0);
    rd(16'h0a40, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      wr(mpcap_pkg::ADDR_CMD_A, cv[i]);
      rd(mpcap_pkg::ADDR_CMD_A, ev[i]);
    end
    $display("test command decode done");
    wr(mpcap_pkg::ADDR_EDGE_A, {30'h0, mpcap_pkg::EDGE_RISE});
    rd(mpcap_pkg::ADDR_EDGE_A, 32'h1);
    wr(mpcap_pkg::ADDR_CMD_A, mpcap_pkg::CMD_ONCE);
    last = $urandom;
    i_position = last;
    TRIG.pulse(1'b0, 6);
    chk_stat(2'b01);
    i_position = $urandom;
    TRIG.pulse(1'b0, 6);
    rd(mpcap_pkg::ADDR_CNT_A, 32'h1);
    rd(mpcap_pkg::ADDR_POS_A, last);
    rd(mpcap_pkg::ADDR_CMD_A, 32'h0);
    $display("test single shot done");
    wr(mpcap_pkg::ADDR_EDGE_B, 32'h2);
    rd(mpcap_pkg::ADDR_EDGE_B, 32'h0);
    wr(mpcap_pkg::ADDR_CMD_B, mpcap_pkg::CMD_CONT);
    for (int i = 0; i < 3; i++)
    begin
      last = $urandom;
      i_position = last;
      TRIG.pulse(1'b1, 5);
    end
    chk_stat(2'b11);
    rd(mpcap_pkg::ADDR_CNT_B, 32'h3);
    rd(mpcap_pkg::ADDR_POS_B, last);
    rd(mpcap_pkg::ADDR_CMD_B, 32'h2);
    i_position = $urandom;
    TRIG.pulse(1'b1, 5);
    rd(mpcap_pkg::ADDR_POS_B, last);
    last = i_position;
    rd(mpcap_pkg::ADDR_CNT_B, 32'h4);
    rd(mpcap_pkg::ADDR_POS_B, last);
    $display("test continuous done");
    i_pos_delta = $urandom;
    @(negedge i_clk);
    i_pos_set = 1'b1;
    @(negedge i_clk);
    i_pos_set = 1'b0;
    rd(mpcap_pkg::ADDR_POS_B, last + i_pos_delta);
    wr(mpcap_pkg::ADDR_CMD_B, mpcap_pkg::CMD_STOP);
    TRIG.pulse(1'b1, 5);
    rd(mpcap_pkg::ADDR_CNT_B, 32'h4);
    rd(mpcap_pkg::ADDR_POS_B, last + i_pos_delta);
    $display("test redefine and cancel done");
    wr(mpcap_pkg::ADDR_EDGE_A, {30'h0, mpcap_pkg::EDGE_BOTH});
    wr(mpcap_pkg::ADDR_CMD_A, mpcap_pkg::CMD_CONT);
    chk_stat(2'b10);
    rd(mpcap_pkg::ADDR_CNT_A, 32'h0);
    TRIG.pulse(1'b0, 6);
    rd(mpcap_pkg::ADDR_CNT_A, 32'h2);
    $display("test both edges done");
    chk("one channel status", 32'h1, {30'h0, status1});
    @(negedge i_clk);
    i_reset_n = 1'b0;
    repeat (2) @(negedge i_clk);
    i_reset_n = 1'b1;
    rd(mpcap_pkg::ADDR_STATUS, 32'h0);
    rd(mpcap_pkg::ADDR_CMD_A, 32'h0);
    rd(mpcap_pkg::ADDR_CNT_A, 32'h0);
    $display("test mid-run reset done");
    repeat (4) @(negedge i_clk);
    chk("pending notes", 32'h0, expq.size());
    conclude();
  end
endmodule
